// *** shared/ext_dma_consts.vh ***
// register map, field positions and reset values of the transfer controller
`ifndef EXT_DMA_CONSTS_VH
`define EXT_DMA_CONSTS_VH

// ==========================================
// register offsets inside one channel window
`define EDMA_OFS_SRC   4'h0
`define EDMA_OFS_DST   4'h4
`define EDMA_OFS_CNT   4'h8
`define EDMA_OFS_MODE  4'hC
// channel number sits in address bits 5:4
`define EDMA_CH_LO     4
`define EDMA_CH_HI     5

// ==========================================
// mode register fields
`define EDMA_F_EN      0
`define EDMA_F_WORD    1
`define EDMA_F_SINGLE  2
`define EDMA_F_DEVSRC  3
`define EDMA_F_BURST   4
`define EDMA_F_BLOCK   5
`define EDMA_F_AUTO    6
`define EDMA_F_IRQEN   7
`define EDMA_F_SINC    8
`define EDMA_F_DINC    9
`define EDMA_F_BUSY    14
`define EDMA_F_DONE    15
`define EDMA_F_BLK_LO  16
`define EDMA_F_BLK_HI  23
`define EDMA_MODE_WMASK 24'hFF03FF

// ==========================================
// reset values
`define EDMA_MODE_RST  24'h000000
`define EDMA_CNT_RST   24'h000000

`endif

// *** hw/external_bus_transfer_controller.v ***
// four-channel external bus transfer controller with register port
//
// Implementation choices: the strobed register port and the address map.
`include "ext_dma_consts.vh"

// How it works
// R1 - four independent channels move data over the external bus for the cpu
// R2 - source and destination addresses are 24 bits, covering 16 Mbyte
// R3 - each channel moves bytes or words as software chooses
// R4 - count up to 16,777,215; count zero runs free with no end
// R5 - dual address mode reads then writes; single mode uses acknowledged device
// R6 - cycle-steal releases after each unit, burst keeps the bus
// R7 - normal mode or block mode moving a whole block per request
// R8 - a channel starts on its request pin or on auto-request
// R9 - interrupt raised on count end when enabled
// R10 - external device drives its request pin to ask for transfers
// R11 - acknowledge output selects the device in single address transfers
// R12 - transfer-end output marks the final transfer of a channel
// R13 - acceptance output tells the device its request was taken
// R14 - source address is 32 bits, upper 8 read zero, ignore writes
// R15 - source address steps to the next address after each transfer
// R16 - single mode with device as source ignores source address
// R17 - destination address is 32 bits, upper 8 read zero, ignore writes
// R18 - destination address steps to the next address after each transfer
// R19 - single mode with device as destination ignores destination address
// R20 - software reads busy address registers with one longword access
// R21 - software does not write address registers during a transfer
// R22 - address registers readable any time; no reset value
// R23 - a longword read returns one coherent 24-bit address
module external_bus_transfer_controller (
  // clock and reset
  input  wire        I_SYS_CLK,
  input  wire        I_SRST,
  // register port
  input  wire [5:0]  I_REG_ADDR,
  input  wire [31:0] I_REG_WDATA,
  input  wire        I_REG_WR,
  input  wire        I_REG_RD,
  output reg  [31:0] O_REG_RDATA,
  // device handshake pins
  input  wire [3:0]  I_EXT_TRANSFER_REQUEST_IN,
  output reg  [3:0]  O_SINGLE_ADDR_DEVICE_ACK_OUT,
  output reg  [3:0]  O_FINAL_TRANSFER_MARKER_OUT,
  output reg  [3:0]  O_REQUEST_ACCEPTED_NOTIFY_OUT,
  output reg  [3:0]  O_IRQ,
  // external bus master side
  output reg  [23:0] O_BUS_ADDR,
  output reg         O_BUS_RD,
  output reg         O_BUS_WR,
  output reg         O_BUS_WORD,
  output reg  [15:0] O_BUS_WDATA,
  input  wire [15:0] I_BUS_RDATA
);

  localparam NCH      = 4;
  localparam ST_IDLE  = 5'h01;
  localparam ST_READ  = 5'h02;
  localparam ST_RDATA = 5'h04;
  localparam ST_WRITE = 5'h08;
  localparam ST_STEP  = 5'h10;

  // ==========================================
  // storage
  // R2 24-bit addresses
  reg  [23:0] src_reg  [0:NCH-1];
  reg  [23:0] dst_reg  [0:NCH-1];
  reg  [23:0] cnt_reg  [0:NCH-1];
  reg  [23:0] mode_reg [0:NCH-1];
  reg  [3:0]  done_reg;
  reg  [3:0]  req_s1_reg;
  reg  [3:0]  req_s2_reg;
  reg  [4:0]  state_reg;
  reg  [1:0]  ch_reg;
  reg         lock_reg;
  reg  [8:0]  blk_reg;
  reg  [3:0]  pend;
  reg  [1:0]  gnt_ch;
  reg         gnt_ok;
  // separate loop indices keep each process the only writer of its own variable
  integer     c;
  integer     k;

  wire [1:0]  rsel   = I_REG_ADDR[`EDMA_CH_HI:`EDMA_CH_LO];
  wire [3:0]  rofs   = I_REG_ADDR[3:0];
  wire [23:0] cm     = mode_reg[ch_reg];
  wire [23:0] gm     = mode_reg[gnt_ch];
  // R3 step of one byte or one word
  wire [23:0] step   = {22'h000000, cm[`EDMA_F_WORD], ~cm[`EDMA_F_WORD]};
  wire [7:0]  bsz    = gm[`EDMA_F_BLK_HI:`EDMA_F_BLK_LO];
  wire [8:0]  blk_ld = {(bsz == 8'h00), bsz};
  wire        last   = (cnt_reg[ch_reg] == 24'h000001);

  // ==========================================
  // request pins: two flip-flops before any use
  always @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      req_s1_reg <= 4'h0;
      req_s2_reg <= 4'h0;
    end else begin
      req_s1_reg <= I_EXT_TRANSFER_REQUEST_IN;
      req_s2_reg <= req_s1_reg;
    end
  end

  // ==========================================
  // request and arbitration
  always @* begin
    gnt_ch = 2'h0;
    gnt_ok = 1'b0;
    for (k = 0; k < NCH; k = k + 1) begin
      // R8 pin or auto-request
      // R10 device holds its request
      pend[k] = mode_reg[k][`EDMA_F_EN] &
                (mode_reg[k][`EDMA_F_AUTO] | req_s2_reg[k]);
    end
    // fixed priority, lowest channel first
    for (k = NCH - 1; k >= 0; k = k - 1) begin
      if (pend[k]) begin
        gnt_ch = k[1:0];
        gnt_ok = 1'b1;
      end
    end
    // R6 burst keeps the bus
    // R7 block stays on channel
    if (lock_reg && pend[ch_reg]) begin
      gnt_ch = ch_reg;
      gnt_ok = 1'b1;
    end
  end

  // ==========================================
  // registers and transfer engine
  always @(posedge I_SYS_CLK) begin
    // R14 upper bits dropped
    // R17 upper bits dropped
    // R21 engine update wins
    if (I_REG_WR) begin
      case (rofs)
        `EDMA_OFS_SRC:  src_reg[rsel] <= I_REG_WDATA[23:0];
        `EDMA_OFS_DST:  dst_reg[rsel] <= I_REG_WDATA[23:0];
        default: ;
      endcase
    end
    if (I_SRST) begin
      state_reg                     <= ST_IDLE;
      ch_reg                        <= 2'h0;
      lock_reg                      <= 1'b0;
      blk_reg                       <= 9'h000;
      done_reg                      <= 4'h0;
      O_SINGLE_ADDR_DEVICE_ACK_OUT  <= 4'h0;
      O_FINAL_TRANSFER_MARKER_OUT   <= 4'h0;
      O_REQUEST_ACCEPTED_NOTIFY_OUT <= 4'h0;
      O_IRQ                         <= 4'h0;
      O_BUS_ADDR                    <= 24'h000000;
      O_BUS_RD                      <= 1'b0;
      O_BUS_WR                      <= 1'b0;
      O_BUS_WORD                    <= 1'b0;
      O_BUS_WDATA                   <= 16'h0000;
      O_REG_RDATA                   <= 32'h00000000;
      for (c = 0; c < NCH; c = c + 1) begin
        cnt_reg[c]  <= `EDMA_CNT_RST;
        mode_reg[c] <= `EDMA_MODE_RST;
      end
    end else begin
      O_REQUEST_ACCEPTED_NOTIFY_OUT <= 4'h0;
      // R9 end interrupt
      for (c = 0; c < NCH; c = c + 1) begin
        O_IRQ[c] <= done_reg[c] & mode_reg[c][`EDMA_F_IRQEN];
      end
      // software writes; enabling a channel clears its done flag
      if (I_REG_WR && rofs == `EDMA_OFS_CNT) begin
        cnt_reg[rsel] <= I_REG_WDATA[23:0];
      end
      if (I_REG_WR && rofs == `EDMA_OFS_MODE) begin
        mode_reg[rsel] <= I_REG_WDATA[23:0] & `EDMA_MODE_WMASK;
        if (I_REG_WDATA[`EDMA_F_EN]) begin
          done_reg[rsel] <= 1'b0;
        end
      end

      // R22 reads at any time
      // R23 whole word in one cycle
      // R20 single longword read
      if (I_REG_RD) begin
        case (rofs)
          `EDMA_OFS_SRC:  O_REG_RDATA <= {8'h00, src_reg[rsel]};
          `EDMA_OFS_DST:  O_REG_RDATA <= {8'h00, dst_reg[rsel]};
          `EDMA_OFS_CNT:  O_REG_RDATA <= {8'h00, cnt_reg[rsel]};
          `EDMA_OFS_MODE: O_REG_RDATA <= {8'h00, mode_reg[rsel][23:16],
                                         done_reg[rsel],
                                         (state_reg != ST_IDLE) && (ch_reg == rsel),
                                         4'h0, mode_reg[rsel][9:0]};
          default:        O_REG_RDATA <= 32'h00000000;
        endcase
      end else begin
        O_REG_RDATA <= 32'h00000000;
      end

      case (state_reg)
        ST_IDLE: begin
          if (gnt_ok) begin
            ch_reg     <= gnt_ch;
            O_BUS_WORD <= gm[`EDMA_F_WORD];
            if (!(lock_reg && gnt_ch == ch_reg)) begin
              blk_reg <= blk_ld;
            end
            // R13 acceptance pulse
            if (!gm[`EDMA_F_AUTO] && !(lock_reg && gnt_ch == ch_reg)) begin
              O_REQUEST_ACCEPTED_NOTIFY_OUT[gnt_ch] <= 1'b1;
            end
            // R12 final transfer mark
            O_FINAL_TRANSFER_MARKER_OUT[gnt_ch] <= (cnt_reg[gnt_ch] == 24'h000001);
            // R11 single address ack
            O_SINGLE_ADDR_DEVICE_ACK_OUT[gnt_ch] <= gm[`EDMA_F_SINGLE];
            // R5 dual or single
            // R16 device source, only destination
            if (gm[`EDMA_F_SINGLE] && gm[`EDMA_F_DEVSRC]) begin
              O_BUS_WR   <= 1'b1;
              O_BUS_ADDR <= dst_reg[gnt_ch];
              state_reg  <= ST_WRITE;
            end else begin
              O_BUS_RD   <= 1'b1;
              O_BUS_ADDR <= src_reg[gnt_ch];
              state_reg  <= ST_READ;
            end
          end
        end
        ST_READ: begin
          O_BUS_RD  <= 1'b0;
          state_reg <= ST_RDATA;
        end
        ST_RDATA: begin
          // R19 device destination, no write
          if (cm[`EDMA_F_SINGLE]) begin
            O_SINGLE_ADDR_DEVICE_ACK_OUT <= 4'h0;
            state_reg                    <= ST_STEP;
          end else begin
            O_BUS_WDATA <= cm[`EDMA_F_WORD] ? I_BUS_RDATA
                                            : {8'h00, I_BUS_RDATA[7:0]};
            O_BUS_WR    <= 1'b1;
            O_BUS_ADDR  <= dst_reg[ch_reg];
            state_reg   <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          O_BUS_WR                     <= 1'b0;
          O_SINGLE_ADDR_DEVICE_ACK_OUT <= 4'h0;
          state_reg                    <= ST_STEP;
        end
        ST_STEP: begin
          O_FINAL_TRANSFER_MARKER_OUT <= 4'h0;
          // R15 source steps
          if (cm[`EDMA_F_SINC] && !(cm[`EDMA_F_SINGLE] && cm[`EDMA_F_DEVSRC])) begin
            src_reg[ch_reg] <= src_reg[ch_reg] + step;
          end
          // R18 destination steps
          if (cm[`EDMA_F_DINC] && !(cm[`EDMA_F_SINGLE] && !cm[`EDMA_F_DEVSRC])) begin
            dst_reg[ch_reg] <= dst_reg[ch_reg] + step;
          end
          // R4 zero count runs free
          if (cnt_reg[ch_reg] != 24'h000000) begin
            cnt_reg[ch_reg] <= cnt_reg[ch_reg] - 24'h000001;
          end
          // done set after any clear, so the set wins
          if (last) begin
            mode_reg[ch_reg][`EDMA_F_EN] <= 1'b0;
            done_reg[ch_reg]             <= 1'b1;
          end
          blk_reg   <= blk_reg - 9'h001;
          // R6 cycle steal releases
          // R7 block holds until block ends
          lock_reg  <= !last && (cm[`EDMA_F_BURST] ||
                       (cm[`EDMA_F_BLOCK] && blk_reg > 9'h001));
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // R1 four channels share one engine; each keeps its own registers
endmodule // external_bus_transfer_controller

// *** verification/ext_dma_props.sv ***
// port checker of the external bus transfer controller
module ext_dma_props (
  input wire        I_SYS_CLK,
  input wire        I_SRST,
  input wire        I_REG_RD,
  input wire [31:0] O_REG_RDATA,
  input wire [3:0]  O_SINGLE_ADDR_DEVICE_ACK_OUT,
  input wire [3:0]  O_FINAL_TRANSFER_MARKER_OUT,
  input wire [3:0]  O_REQUEST_ACCEPTED_NOTIFY_OUT,
  input wire        O_BUS_RD,
  input wire        O_BUS_WR
);
  // ==========================================
  // bus unit steps, register read data and handshake pulses
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_SRST);
  sequence s_rd_unit;
    O_BUS_RD ##1 (!O_BUS_RD && !O_BUS_WR);
  endsequence
  sequence s_wr_step;
    O_BUS_WR ##1 (!O_BUS_WR && !O_BUS_RD);
  endsequence
  rd_pulse_a:
    assert property (O_BUS_RD |-> s_rd_unit) else $error("read strobe not one cycle");
  wr_pulse_a:
    assert property (O_BUS_WR |-> s_wr_step) else $error("write strobe not one cycle");
  rdata_quiet_a:
    assert property (!$past(I_REG_RD) |-> O_REG_RDATA == 32'h0) else $error("stray read data");
  rdata_top_a:
    assert property (O_REG_RDATA[31:24] == 8'h00) else $error("upper byte not zero");
  accept_pulse_a:
    assert property (|O_REQUEST_ACCEPTED_NOTIFY_OUT |=> O_REQUEST_ACCEPTED_NOTIFY_OUT == 4'h0)
      else $error("acceptance longer than a cycle");
  accept_strobe_a:
    assert property (|O_REQUEST_ACCEPTED_NOTIFY_OUT |-> (O_BUS_RD || O_BUS_WR))
      else $error("acceptance without bus cycle");
  ack_start_a:
    assert property ($rose(|O_SINGLE_ADDR_DEVICE_ACK_OUT) |-> (O_BUS_RD || O_BUS_WR))
      else $error("acknowledge without bus cycle");
  ack_single_a:
    assert property ($onehot0(O_SINGLE_ADDR_DEVICE_ACK_OUT)) else $error("two acknowledges");
  marker_start_a:
    assert property ($rose(|O_FINAL_TRANSFER_MARKER_OUT) |-> (O_BUS_RD || O_BUS_WR))
      else $error("end marker without bus cycle");
endmodule // ext_dma_props
bind external_bus_transfer_controller ext_dma_props ext_dma_props_inst (.*);

// *** verification/ext_dma_far_side.sv ***
// far-side memory and requesting devices of the transfer controller
module ext_dma_far_side (
  input  wire  logic        i_clk,
  input  wire  logic [23:0] i_bus_addr,
  input  wire  logic        i_bus_rd,
  input  wire  logic [3:0]  i_want,
  output logic       [15:0] o_rdata,
  output logic       [3:0]  o_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // memory and request pins
  initial begin
    o_rdata = 16'h0;
    o_req = 4'h0;
  end
  always @(posedge i_clk) begin
    o_req <= i_want;
    // data lives one cycle only, then inverts each cycle so a value one cycle stale never matches
    o_rdata <= i_bus_rd ? (i_bus_addr[15:0] ^ 16'h5A3C) : ~o_rdata;
  end
endmodule // ext_dma_far_side

// *** verification/external_bus_transfer_controller_tb.sv ***
// self-checking bench of the external bus transfer controller
`include "ext_dma_consts.vh"
module external_bus_transfer_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        srst;
  logic [5:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [3:0]  req;
  logic [3:0]  want;
  logic [3:0]  ack;
  logic [3:0]  rak;
  logic [3:0]  irq;
  logic [23:0] baddr;
  logic        brd;
  logic        bwr;
  logic [15:0] brdata;
  logic [31:0] seed;
  int          n_mismatch;
  int          n_tests;
  int          n_rak = 0;
  int          n_ack = 0;
  int          n_units = 0;
  int          n_mark = 0;
  int          n_word = 0;
  logic [3:0]  mark;
  logic        bword;
  logic [15:0] bwdata;
  logic [15:0] last_wd;
  logic [23:0] last_ra;
  // ==========================================
  // design, far side and clock
  external_bus_transfer_controller external_bus_transfer_controller_inst (
    .I_SYS_CLK(clk), .I_SRST(srst), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_EXT_TRANSFER_REQUEST_IN(req),
    .O_SINGLE_ADDR_DEVICE_ACK_OUT(ack), .O_FINAL_TRANSFER_MARKER_OUT(mark),
    .O_REQUEST_ACCEPTED_NOTIFY_OUT(rak), .O_IRQ(irq), .O_BUS_ADDR(baddr), .O_BUS_RD(brd),
    .O_BUS_WR(bwr), .O_BUS_WORD(bword), .O_BUS_WDATA(bwdata), .I_BUS_RDATA(brdata));
  ext_dma_far_side ext_dma_far_side_inst (.i_clk(clk), .i_bus_addr(baddr), .i_bus_rd(brd),
    .i_want(want), .o_rdata(brdata), .o_req(req));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    n_rak <= n_rak + int'(rak != 4'h0);
    n_ack <= n_ack + int'(ack != 4'h0);
    n_units <= n_units + int'(brd) + int'(bwr);
    n_mark <= n_mark + int'(mark != 4'h0);
    n_word <= n_word + int'((brd || bwr) && bword);
    if (brd)
      last_ra <= baddr;
    if (bwr)
      last_wd <= bwdata;
  end
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one channel run: program, start, wait for done, check what moved
  task automatic run(input logic [1:0] ch, input logic [23:0] m, input logic [23:0] s,
                     input logic [23:0] d, input logic [23:0] c);
    logic [31:0] v;
    logic [23:0] stp;
    logic        sgl;
    logic        dsrc;
    logic [15:0] ev;
    int          r0;
    int          a0;
    int          u0;
    int          k0;
    int          w0;
    stp = m[`EDMA_F_WORD] ? c + c : c;
    sgl = m[`EDMA_F_SINGLE];
    dsrc = m[`EDMA_F_DEVSRC];
    // addresses written only while the channel is idle
    reg_wr({ch, `EDMA_OFS_SRC}, {8'hFF, s});
    reg_wr({ch, `EDMA_OFS_DST}, {8'hFF, d});
    reg_wr({ch, `EDMA_OFS_CNT}, {8'h00, c});
    reg_rd({ch, `EDMA_OFS_SRC}, v);
    chk("source", v, {8'h00, s});
    reg_rd({ch, `EDMA_OFS_DST}, v);
    chk("destination", v, {8'h00, d});
    r0 = n_rak;
    a0 = n_ack;
    u0 = n_units;
    k0 = n_mark;
    w0 = n_word;
    reg_wr({ch, `EDMA_OFS_MODE}, {8'h00, m});
    want[ch] <= !m[`EDMA_F_AUTO];
    v = 32'h0;
    for (int k = 0; k < 400 && !v[`EDMA_F_DONE]; k++)
      reg_rd({ch, `EDMA_OFS_MODE}, v);
    @(posedge clk);
    want[ch] <= 1'b0;
    chk("mode", v, {8'h00, (m & `EDMA_MODE_WMASK & 24'hFFFFFE) | 24'h008000});
    reg_rd({ch, `EDMA_OFS_SRC}, v);
    chk("source step", v, {8'h00, (sgl && dsrc) ? s : s + stp});
    reg_rd({ch, `EDMA_OFS_DST}, v);
    chk("dest step", v, {8'h00, (sgl && !dsrc) ? d : d + stp});
    reg_rd({ch, `EDMA_OFS_CNT}, v);
    chk("count", v, 32'h0);
    chk("units", 32'(n_units - u0), sgl ? 32'(c) : 32'(c + c));
    chk("accept", 32'(n_rak != r0), 32'(!m[`EDMA_F_AUTO]));
    chk("acknowledge", 32'(n_ack != a0), 32'(sgl));
    chk("end marker", 32'(n_mark - k0), sgl ? (dsrc ? 32'h2 : 32'h3) : 32'h4);
    chk("word strobes", 32'(n_word - w0),
        m[`EDMA_F_WORD] ? (sgl ? 32'(c) : 32'(c + c)) : 32'h0);
    ev = last_ra[15:0] ^ 16'h5A3C;
    if (!sgl)
      chk("write data", {16'h0, last_wd}, m[`EDMA_F_WORD] ? {16'h0, ev} : {24'h0, ev[7:0]});
    chk("irq", 32'(irq[ch]), 32'(m[`EDMA_F_IRQEN]));
    // masking the enable must drop the line while done stays
    reg_wr({ch, `EDMA_OFS_MODE}, {8'h00, m & 24'hFFFF7E});
    repeat (2) @(posedge clk);
    #1 chk("irq masked", 32'(irq[ch]), 32'h0);
    $display("run ch %0d mode %h count %0d done", ch, m, c);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    srst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 6'h0;
    wdata = 32'h0;
    want = 4'h0;
    seed = 32'h4A19;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // corner: word unit at the top of the 24-bit space wraps source to zero, destination to one
    run(2'h0, 24'h0003C3, 24'hFFFFFE, 24'hFFFFFF, 24'h000001);
    for (int i = 0; i < 16; i++) begin
      logic [31:0] ra;
      logic [31:0] rb;
      seed = xs(seed);
      ra = xs(seed ^ 32'h1);
      rb = xs(seed ^ 32'h2);
      run(seed[1:0], {seed[23:16], 8'h03, seed[31:25], 1'b1}, ra[23:0],
          rb[23:0], {21'h0, seed[4:2]} + 24'h1);
    end
    report_and_stop();
  end
  initial begin
    #(20 * 60000);
    n_mismatch++;
    report_and_stop();
  end
endmodule // external_bus_transfer_controller_tb
